// [logic/bsiu_pkg.sv]
// Constants and types of the boundary-scan instruction unit.
// Assumes one instance per channel, chained externally on tdi/tdo.
package bsiu_pkg;
  // ==========================================
  // Register widths
  localparam int IR_W = 8;
  localparam int BS_W = 48;
  localparam int ID_W = 32;
  localparam int TEMP_W = 8;
  // ==========================================
  // Instruction codes
  localparam logic [7:0] OP_BYPASS0 = 8'h00;
  localparam logic [7:0] OP_SAMPLE = 8'h01;
  localparam logic [7:0] OP_IDCODE = 8'h02;
  localparam logic [7:0] OP_CLAMP = 8'h04;
  localparam logic [7:0] OP_HIGHZ = 8'h08;
  localparam logic [7:0] OP_EXTEST = 8'h10;
  localparam logic [7:0] OP_TEMP = 8'h20;
  localparam logic [7:0] OP_BYPASS1 = 8'hff;
  // Fixed pattern for capture-IR
  localparam logic [7:0] IR_CAPTURE = 8'h01;
  // Arbitrary identification value, bit 0 set
  localparam logic [31:0] ID_DEFAULT = 32'h0a5c_3e71;
  // ==========================================
  // Tap controller states
  typedef enum logic [3:0] {
    TLR = 4'h0, RTI = 4'h1, SEL_DR = 4'h2, CAP_DR = 4'h3,
    SH_DR = 4'h4, EX1_DR = 4'h5, PA_DR = 4'h6, EX2_DR = 4'h7,
    UPD_DR = 4'h8, SEL_IR = 4'h9, CAP_IR = 4'ha, SH_IR = 4'hb,
    EX1_IR = 4'hc, PA_IR = 4'hd, EX2_IR = 4'he, UPD_IR = 4'hf
  } bsiu_tap_t;
  // Selected serial path
  typedef enum logic [1:0] {
    SEL_BYP = 2'h0, SEL_BS = 2'h1, SEL_ID = 2'h2, SEL_TMP = 2'h3
  } bsiu_sel_t;
endpackage

// [logic/bsiu_top.sv]
// Boundary-scan instruction unit of one channel: tap, instruction
// decode, data registers, pin takeover and command decoder disable.
// Assumes tck_i from the board tester; pin_in_i and temp_i stable
// around capture; nrst_i resets both domains.
//
// Summary of operation
// - Codes 00 and ff select bypass.
// - Code 01 selects 48-bit boundary register.
// - Code 02 captures and shifts identification.
// - Identification instruction at reset and idle-reset.
// - Clamp drives latched outputs, bypass, holds.
// - High-Z floats pins, bypass selected.
// - Extest updates on falling, captures inputs.
// - Code 20 reads temperature, harmless.
// - Unknown codes act as bypass here.
// - Sample snapshots pins at capture-DR.
// - Preloaded data driven when extest lands.
// - Capture, shift, update data register.
// - Non-intrusive codes leave decoder running.
// - Takeover codes disable decoder, reset channel.
// - Test-logic-reset re-enables decoder, releases pins.
// - Serial output changes after falling edge.
// - Least significant bit shifts out first.
// - Capture-IR loads pattern 01.
// - Bypass cell captures zero.
`timescale 1ns/1ps
module bsiu_top #(
  parameter logic [31:0] ID_VALUE = bsiu_pkg::ID_DEFAULT // Arbitrary
) (
  // System clock and reset
  input wire logic mclk_i,
  input wire logic nrst_i,
  // Test port
  input wire logic tck_i,
  input wire logic tms_i,
  input wire logic tdi_i,
  output logic tdo_o,
  output logic tdo_oe_o,
  // Boundary cells and sensor
  input wire logic [47:0] pin_in_i,
  input wire logic [7:0] temp_i,
  output logic [47:0] bs_out_o,
  output logic pin_drive_o,
  output logic pin_hiz_o,
  // Functional channel control
  output logic decoder_en_o,
  output logic chan_rst_o
);
  // ==========================================
  // State types
  typedef struct packed {
    bsiu_pkg::bsiu_tap_t st; // Tap state
    logic [7:0] ir_sh; // Instruction shift stage
    logic [47:0] dr_sh; // Shared data shift stage
  } bsiu_pos_t;

  typedef struct packed {
    logic tdo; // Serial output
    logic tdo_oe; // Output enable
    logic [7:0] ir; // Active instruction
    logic [47:0] upd; // Boundary update latches
    logic drive; // Pins from boundary latches
    logic hiz; // Pins floated
    logic tmode; // Channel taken over
  } bsiu_neg_t;

  typedef struct packed {
    logic [2:0] sy; // Takeover synchroniser
    logic dec_en; // Command decoder enable
    logic ch_rst; // Channel held in reset
  } bsiu_sys_t;

  bsiu_pos_t p_q, p_d;
  bsiu_neg_t n_q, n_d;
  bsiu_sys_t s_q, s_d;
  bsiu_pkg::bsiu_sel_t sel;

  // ==========================================
  // Tap next state
  function automatic bsiu_pkg::bsiu_tap_t tap_next(
    input bsiu_pkg::bsiu_tap_t s, input logic m);
    unique case (s)
      bsiu_pkg::TLR: tap_next = m ? bsiu_pkg::TLR : bsiu_pkg::RTI;
      bsiu_pkg::RTI: tap_next = m ? bsiu_pkg::SEL_DR : bsiu_pkg::RTI;
      bsiu_pkg::SEL_DR: tap_next = m ? bsiu_pkg::SEL_IR : bsiu_pkg::CAP_DR;
      bsiu_pkg::CAP_DR: tap_next = m ? bsiu_pkg::EX1_DR : bsiu_pkg::SH_DR;
      bsiu_pkg::SH_DR: tap_next = m ? bsiu_pkg::EX1_DR : bsiu_pkg::SH_DR;
      bsiu_pkg::EX1_DR: tap_next = m ? bsiu_pkg::UPD_DR : bsiu_pkg::PA_DR;
      bsiu_pkg::PA_DR: tap_next = m ? bsiu_pkg::EX2_DR : bsiu_pkg::PA_DR;
      bsiu_pkg::EX2_DR: tap_next = m ? bsiu_pkg::UPD_DR : bsiu_pkg::SH_DR;
      bsiu_pkg::UPD_DR: tap_next = m ? bsiu_pkg::SEL_DR : bsiu_pkg::RTI;
      bsiu_pkg::SEL_IR: tap_next = m ? bsiu_pkg::TLR : bsiu_pkg::CAP_IR;
      bsiu_pkg::CAP_IR: tap_next = m ? bsiu_pkg::EX1_IR : bsiu_pkg::SH_IR;
      bsiu_pkg::SH_IR: tap_next = m ? bsiu_pkg::EX1_IR : bsiu_pkg::SH_IR;
      bsiu_pkg::EX1_IR: tap_next = m ? bsiu_pkg::UPD_IR : bsiu_pkg::PA_IR;
      bsiu_pkg::PA_IR: tap_next = m ? bsiu_pkg::EX2_IR : bsiu_pkg::PA_IR;
      bsiu_pkg::EX2_IR: tap_next = m ? bsiu_pkg::UPD_IR : bsiu_pkg::SH_IR;
      bsiu_pkg::UPD_IR: tap_next = m ? bsiu_pkg::SEL_DR : bsiu_pkg::RTI;
    endcase
  endfunction

  // ==========================================
  // Instruction decode
  // Unlisted codes fall to bypass, the safest path for a chain
  always_comb
  begin
    unique case (n_q.ir)
      bsiu_pkg::OP_SAMPLE: sel = bsiu_pkg::SEL_BS;
      bsiu_pkg::OP_EXTEST: sel = bsiu_pkg::SEL_BS;
      bsiu_pkg::OP_IDCODE: sel = bsiu_pkg::SEL_ID;
      bsiu_pkg::OP_TEMP: sel = bsiu_pkg::SEL_TMP;
      default: sel = bsiu_pkg::SEL_BYP;
    endcase
  end

  // ==========================================
  // Rising edge: tap, capture and shift
  always_comb
  begin
    p_d = p_q;
    p_d.st = tap_next(p_q.st, tms_i);
    unique case (p_q.st)
      bsiu_pkg::CAP_IR: p_d.ir_sh = bsiu_pkg::IR_CAPTURE;
      bsiu_pkg::SH_IR:
      begin
        // Eight stages; the next channel sits on tdi
        p_d.ir_sh = {tdi_i, p_q.ir_sh[7:1]};
      end
      bsiu_pkg::CAP_DR:
      begin
        // Parallel load of the selected register
        unique case (sel)
          bsiu_pkg::SEL_BYP: p_d.dr_sh = '0;
          bsiu_pkg::SEL_ID: p_d.dr_sh = {16'h0000, ID_VALUE};
          bsiu_pkg::SEL_TMP: p_d.dr_sh = {40'h00_0000_0000, temp_i};
          bsiu_pkg::SEL_BS: p_d.dr_sh = pin_in_i;
        endcase
      end
      bsiu_pkg::SH_DR:
      begin
        // Low bits move toward tdo; tdi enters the top of the path
        p_d.dr_sh = {1'b0, p_q.dr_sh[47:1]};
        unique case (sel)
          bsiu_pkg::SEL_BYP: p_d.dr_sh[0] = tdi_i;
          bsiu_pkg::SEL_ID: p_d.dr_sh[31] = tdi_i;
          bsiu_pkg::SEL_TMP: p_d.dr_sh[7] = tdi_i;
          bsiu_pkg::SEL_BS: p_d.dr_sh[47] = tdi_i;
        endcase
      end
      default:
      begin
        // Other states hold the stages
        p_d.dr_sh = p_q.dr_sh;
      end
    endcase
  end

  // Rising-edge registers
  always_ff @(posedge tck_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      p_q <= '{st: bsiu_pkg::TLR, ir_sh: 8'h00, dr_sh: 48'h0000_0000_0000};
    end
    else
    begin
      p_q <= p_d;
    end
  end

  // ==========================================
  // Falling edge: instruction, update, pins, tdo
  always_comb
  begin
    n_d = n_q;
    if (p_q.st == bsiu_pkg::TLR)
    begin
      n_d.ir = bsiu_pkg::OP_IDCODE;
    end
    else if (p_q.st == bsiu_pkg::UPD_IR)
    begin
      n_d.ir = p_q.ir_sh;
    end
    // Latches move only under sample or extest, so clamp holds them
    if (p_q.st == bsiu_pkg::UPD_DR && sel == bsiu_pkg::SEL_BS)
    begin
      n_d.upd = p_q.dr_sh;
    end
    // Pin control follows the new instruction on the same edge
    n_d.drive = (n_d.ir == bsiu_pkg::OP_EXTEST) ||
                (n_d.ir == bsiu_pkg::OP_CLAMP);
    n_d.hiz = (n_d.ir == bsiu_pkg::OP_HIGHZ);
    n_d.tmode = n_d.drive || n_d.hiz;
    // Serial output from bit 0 of the active stage
    if (p_q.st == bsiu_pkg::SH_IR)
    begin
      n_d.tdo = p_q.ir_sh[0];
      n_d.tdo_oe = 1'b1;
    end
    else if (p_q.st == bsiu_pkg::SH_DR)
    begin
      n_d.tdo = p_q.dr_sh[0];
      n_d.tdo_oe = 1'b1;
    end
    else
    begin
      n_d.tdo = 1'b0;
      n_d.tdo_oe = 1'b0;
    end
  end

  // Falling-edge registers
  always_ff @(negedge tck_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      n_q <= '{tdo: 1'b0, tdo_oe: 1'b0, ir: bsiu_pkg::OP_IDCODE,
               upd: 48'h0000_0000_0000, drive: 1'b0, hiz: 1'b0,
               tmode: 1'b0};
    end
    else
    begin
      n_q <= n_d;
    end
  end

  // ==========================================
  // System side: takeover crossing
  // Level crossing; a change counts once stages two and three agree
  always_comb
  begin
    s_d = s_q;
    s_d.sy = {s_q.sy[1:0], n_q.tmode};
    if (s_q.sy[2] == s_q.sy[1])
    begin
      s_d.ch_rst = s_q.sy[1];
      s_d.dec_en = !s_q.sy[1];
    end
  end

  // System registers
  always_ff @(posedge mclk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      s_q <= '{sy: 3'h0, dec_en: 1'b1, ch_rst: 1'b0};
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // ==========================================
  // Outputs
  assign tdo_o = n_q.tdo;
  assign tdo_oe_o = n_q.tdo_oe;
  assign bs_out_o = n_q.upd;
  assign pin_drive_o = n_q.drive;
  assign pin_hiz_o = n_q.hiz;
  assign decoder_en_o = s_q.dec_en;
  assign chan_rst_o = s_q.ch_rst;

  // ==========================================
  // Checks
  sequence ir_load_s(logic [7:0] op);
    (p_q.st == bsiu_pkg::UPD_IR) && (p_q.ir_sh == op);
  endsequence

  sequence dr_cap_s(bsiu_pkg::bsiu_sel_t k);
    (p_q.st == bsiu_pkg::CAP_DR) && (sel == k);
  endsequence

  bypass_cap_a: assert property (@(posedge tck_i) disable iff (!nrst_i)
    dr_cap_s(bsiu_pkg::SEL_BYP) |=> (p_q.dr_sh[0] == 1'b0))
    else $error("bypass cell did not capture zero");

  id_cap_a: assert property (@(posedge tck_i) disable iff (!nrst_i)
    dr_cap_s(bsiu_pkg::SEL_ID) |=> (p_q.dr_sh[31:0] == ID_VALUE))
    else $error("identification value not captured");

  ir_cap_a: assert property (@(posedge tck_i) disable iff (!nrst_i)
    (p_q.st == bsiu_pkg::CAP_IR) |=> (p_q.ir_sh == bsiu_pkg::IR_CAPTURE))
    else $error("capture-IR pattern wrong");

  ir_shift_a: assert property (@(posedge tck_i) disable iff (!nrst_i)
    (p_q.st == bsiu_pkg::SH_IR) |=>
      (p_q.ir_sh == {$past(tdi_i), $past(p_q.ir_sh[7:1])}))
    else $error("instruction shift wrong");

  tlr_idcode_a: assert property (@(negedge tck_i) disable iff (!nrst_i)
    (p_q.st == bsiu_pkg::TLR) |=> (n_q.ir == bsiu_pkg::OP_IDCODE) && !n_q.tmode)
    else $error("reset state did not load identification");

  ext_drive_a: assert property (@(negedge tck_i) disable iff (!nrst_i)
    ir_load_s(bsiu_pkg::OP_EXTEST) |=> pin_drive_o && !pin_hiz_o)
    else $error("extest did not drive pins at once");

  clamp_hold_a: assert property (@(negedge tck_i) disable iff (!nrst_i)
    (n_q.ir == bsiu_pkg::OP_CLAMP) |=> $stable(bs_out_o))
    else $error("outputs changed under clamp");

  hiz_pins_a: assert property (@(negedge tck_i) disable iff (!nrst_i)
    (n_q.ir == bsiu_pkg::OP_HIGHZ) |-> pin_hiz_o && !pin_drive_o)
    else $error("pins not floated under high-z");

  tdo_edge_a: assert property (@(negedge tck_i) disable iff (!nrst_i)
    (p_q.st == bsiu_pkg::SH_DR) |=> tdo_oe_o && (tdo_o == $past(p_q.dr_sh[0])))
    else $error("tdo not bit 0 after falling edge");

  dec_off_a: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    n_q.tmode [*5] |=> chan_rst_o && !decoder_en_o)
    else $error("decoder not disabled under takeover");

  dec_on_a: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    !n_q.tmode [*5] |=> !chan_rst_o && decoder_en_o)
    else $error("decoder not re-enabled");
endmodule

// [sim/bsiu_tester.sv]
// Board test controller model: drives tck, tms and tdi in frames.
// Assumes the unit updates tdo after falling tck only.
`timescale 1ns/1ps
module bsiu_tester (
  // Test port
  output logic tck_o,
  output logic tms_o,
  output logic tdi_o,
  input wire logic tdo_i
);
  // ==========================================
  // Clock stands low between frames
  initial
  begin
    tck_o = 1'b0;
    tms_o = 1'b1;
    tdi_o = 1'b0;
  end
  // ==========================================
  // One 15 ns test clock: drive, rise and sample, fall
  task automatic tick(input logic m, input logic d, output logic q);
  begin
    tms_o = m;
    tdi_o = d;
    #7.5;
    q = tdo_i;
    tck_o = 1'b1;
    #7.5;
    tck_o = 1'b0;
  end
  endtask
  // IR or DR frame from idle back to idle, lsb first
  task automatic scan(input bit ir, input logic [47:0] din, input int n,
                      output logic [47:0] dout);
    logic q;
  begin
    dout = '0;
    tick(1'b1, 1'b0, q);
    if (ir)
      tick(1'b1, 1'b0, q);
    tick(1'b0, 1'b0, q);
    tick(1'b0, 1'b0, q);
    for (int i = 0; i < n; i++)
    begin
      tick(i == n - 1, din[i], q);
      dout[i] = q;
    end
    tick(1'b1, 1'b0, q);
    tick(1'b0, 1'b0, q);
    // Released line flips so stale data is never trusted; the short
    // gap keeps the flip apart from the next frame's first drive
    #5;
    tdi_o = ~tdi_o;
    #5;
  end
  endtask
  // Five ones reach test-logic-reset, then idle
  task automatic reset_tap();
    logic q;
  begin
    repeat (5) tick(1'b1, 1'b0, q);
    tick(1'b0, 1'b0, q);
  end
  endtask
endmodule

// [sim/testbench.sv]
// Self-checking bench of the boundary-scan instruction unit.
// Assumes the tester model owns the test port; bench drives pins.
`timescale 1ns/1ps
module testbench;
  // ==========================================
  // Signals
  logic mclk_i;
  logic nrst_i;
  logic [47:0] pin_in_i;
  logic [7:0] temp_i;
  logic tck, tms, tdi, tdo, tdo_oe, drive, hiz, dec_en, ch_rst;
  logic [47:0] bs_out;
  logic [47:0] dout;
  logic [47:0] pat;
  int num_errors = 0;
  int checked = 0;
  int seed = 32'h5df765a3;
  // Every listed code plus one undefined code
  logic [7:0] codes [9] = '{8'h00, 8'h01, 8'h02, 8'h04, 8'h08, 8'h10, 8'h20, 8'hff, 8'h5a};
  bsiu_top DUT (.mclk_i(mclk_i), .nrst_i(nrst_i), .tck_i(tck), .tms_i(tms), .tdi_i(tdi),
    .tdo_o(tdo), .tdo_oe_o(tdo_oe), .pin_in_i(pin_in_i), .temp_i(temp_i),
    .bs_out_o(bs_out), .pin_drive_o(drive), .pin_hiz_o(hiz), .decoder_en_o(dec_en),
    .chan_rst_o(ch_rst));
  bsiu_tester u_tester (.tck_o(tck), .tms_o(tms), .tdi_o(tdi), .tdo_i(tdo));
  // ==========================================
  // System clock, 20 ns
  initial
  begin
    mclk_i = 1'b0;
    forever #10 mclk_i = ~mclk_i;
  end
  // ==========================================
  // Helpers
  task automatic check(input string name, input logic [47:0] seen, input logic [47:0] exp);
  begin
    checked++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("unexpected %s: expected %h seen %h", name, exp, seen);
    end
  end
  endtask
  task automatic stop_test();
  begin
    $display("errors %0d checks %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  end
  endtask
  function automatic logic [47:0] rnd48();
    logic [63:0] r;
  begin
    r = {$random(seed), $random(seed)};
    return r[47:0];
  end
  endfunction
  // Shifted-out word: captured bits first, then fed-in bits
  function automatic logic [47:0] expect_dr(input logic [7:0] c, input logic [47:0] din);
    logic [47:0] cap;
    int len;
  begin
    cap = '0;
    len = 1;
    case (c)
      8'h01, 8'h10:
      begin
        cap = pin_in_i;
        len = 48;
      end
      8'h02:
      begin
        cap = {16'h0, bsiu_pkg::ID_DEFAULT};
        len = 32;
      end
      8'h20:
      begin
        cap = {40'h0, temp_i};
        len = 8;
      end
      default:
        cap = '0;
    endcase
    return (din << len) | cap;
  end
  endfunction
  // Expected {decoder_en, chan_rst, drive, hiz}
  function automatic logic [47:0] expect_mode(input logic [7:0] c);
  begin
    case (c)
      8'h04, 8'h10: return 48'h6;
      8'h08: return 48'h5;
      default: return 48'h8;
    endcase
  end
  endfunction
  task automatic check_mode(input logic [7:0] c);
  begin
    repeat (6) @(posedge mclk_i);
    check("mode", {44'h0, dec_en, ch_rst, drive, hiz}, expect_mode(c));
  end
  endtask
  task automatic ir_load(input logic [7:0] c);
  begin
    u_tester.scan(1'b1, {40'h0, c}, 8, dout);
    check("capture_ir", dout, 48'h01);
  end
  endtask
  // ==========================================
  // Main sequence
  initial
  begin
    // Scheduled so the first reset edge meets processes already waiting
    nrst_i <= 1'b0;
    pin_in_i = '0;
    temp_i = '0;
    repeat (8) @(posedge mclk_i);
    nrst_i <= 1'b1;
    check_mode(8'h02);
    check("tdo_oe", {47'h0, tdo_oe}, 48'h0);
    u_tester.reset_tap();
    pat = rnd48();
    u_tester.scan(1'b0, pat, 48, dout);
    check("id_power_up", dout, expect_dr(8'h02, pat));
    foreach (codes[k])
    begin
      u_tester.reset_tap();
      check_mode(8'h02);
      @(posedge mclk_i);
      pin_in_i <= rnd48();
      temp_i <= 8'($random(seed));
      @(posedge mclk_i);
      pat = rnd48();
      ir_load(codes[k]);
      u_tester.scan(1'b0, pat, 48, dout);
      if (codes[k] != 8'h01)
        check("dr_out", dout, expect_dr(codes[k], pat));
      check_mode(codes[k]);
    end
    // Preload, then extest drives it at once
    u_tester.reset_tap();
    pat = rnd48();
    ir_load(8'h01);
    u_tester.scan(1'b0, pat, 48, dout);
    check("preload", bs_out, pat);
    ir_load(8'h10);
    check("extest_pins", {drive, bs_out}, {1'b1, pat});
    @(posedge mclk_i);
    pin_in_i <= rnd48();
    @(posedge mclk_i);
    u_tester.scan(1'b0, ~pat, 48, dout);
    check("extest_cap", dout, pin_in_i);
    check("extest_upd", bs_out, ~pat);
    ir_load(8'h04);
    u_tester.scan(1'b0, pat, 48, dout);
    check("clamp_hold", bs_out, ~pat);
    // Mid-run device reset with tap return
    @(posedge mclk_i);
    nrst_i <= 1'b0;
    u_tester.reset_tap();
    @(posedge mclk_i);
    nrst_i <= 1'b1;
    check_mode(8'h02);
    check("pins_free", {46'h0, drive, hiz}, 48'h0);
    // Tap sat in test-logic-reset through reset; walk it to idle first
    u_tester.reset_tap();
    u_tester.scan(1'b0, pat, 48, dout);
    check("id_after_reset", dout, expect_dr(8'h02, pat));
    stop_test();
  end
  // Watchdog well beyond the expected run
  initial
  begin
    #300000;
    num_errors++;
    stop_test();
  end
endmodule
